/* hw/acrl_regs.vh */
// register offsets, field positions and reset values of the low control bank
// assumes nothing; definitions only
`ifndef ACRL_REGS_VH
`define ACRL_REGS_VH
`define ACRL_DEV_ADDR 7'h6c
`define ACRL_OFS_ID 8'h00
`define ACRL_OFS_PWR 8'h01
`define ACRL_OFS_DIG 8'h02
// identity value is arbitrary
`define ACRL_ID_VALUE 8'h5a
`define ACRL_PWR_RESET 8'hfd
`define ACRL_DIG_RESET 8'h14
`define ACRL_PWR_CLIP_HI 7
`define ACRL_PWR_CLIP_LO 2
`define ACRL_PWR_SLEEP 1
`define ACRL_PWR_SD_N 0
`define ACRL_DIG_HPF 7
`define ACRL_DIG_RSVD 6
`define ACRL_DIG_BOOST_HI 5
`define ACRL_DIG_BOOST_LO 4
`define ACRL_DIG_SPEED 3
`define ACRL_DIG_FMT_HI 2
`define ACRL_DIG_FMT_LO 0
`define ACRL_DIG_WMASK 8'hbf
`endif

/* hw/acrl_sync.v */
// two-flop synchroniser for pin inputs
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ps
module acrl_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_d,
  output reg o_q
);
  reg meta;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= RESET_VAL;
      o_q <= RESET_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

/* hw/acrl_top.v */
// two-wire slave with the identity, power and digital path control bytes
// assumes an external open-drain resolution of scl/sda and a sample strobe
// How it works
// - identity byte at index zero, never written
// - power bits 7:2 form threshold top bits
// - sleep bit disables power stage, resets 0
// - active-low shutdown bit zero, resets to one
// - bit seven bypasses high-pass filter
// - reserved bit six reads zero, unwritable
// - boost code gives 0/6/12/18 dB
// - bit three selects single or double speed
// - format field decodes six serial formats
// - threshold top bits reset ones, read/write
// - write: address, index, data, each acknowledged
// - read: index write, restart, data, nack
`timescale 1ns/1ps
`include "acrl_regs.vh"
module acrl_top #(
  parameter [6:0] DEV_ADDR = `ACRL_DEV_ADDR
) (
  // clock and reset
  input wire I_CLK,
  input wire I_NRST,
  // two-wire control port
  input wire I_SCL,
  input wire I_SDA,
  output wire O_SDA,
  output wire O_SDA_OE,
  // audio path timing
  input wire I_SAMPLE_STB,
  // applied controls
  output reg [5:0] O_CLIP_THRESHOLD_HI,
  output reg O_AMP_SLEEP,
  output reg O_AMP_SHUTDOWN_N,
  output reg O_POWER_STAGE_EN,
  output reg O_HIGHPASS_SKIP,
  output reg [1:0] O_BOOST,
  output reg [4:0] O_BOOST_DB,
  output reg O_RATE_SPEED_SELECT,
  output reg [2:0] O_FORMAT,
  output reg [4:0] O_FORMAT_BITS,
  output reg O_FORMAT_I2S,
  output reg O_FORMAT_LEFT
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_WRX = 3'd3;
  localparam ST_RTX = 3'd4;
  localparam ST_RACK = 3'd5;
  localparam ST_SKIP = 3'd6;

  wire scl;
  wire sda;
  acrl_sync u_scl (.i_clk(I_CLK), .i_nrst(I_NRST), .i_d(I_SCL), .o_q(scl));
  acrl_sync u_sda (.i_clk(I_CLK), .i_nrst(I_NRST), .i_d(I_SDA), .o_q(sda));

  reg scl_d;
  reg sda_d;
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;

  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] index;
  reg is_read;
  reg have_index;
  reg ack_drive;
  reg sda_low;
  reg [7:0] pwr;
  reg [7:0] dig;
  reg pending;

  // readback mux; the identity byte is a constant so writes cannot reach it
  reg [7:0] rd_data;
  always @* begin
    case (index)
      `ACRL_OFS_ID: rd_data = `ACRL_ID_VALUE;
      `ACRL_OFS_PWR: rd_data = pwr;
      `ACRL_OFS_DIG: rd_data = dig & `ACRL_DIG_WMASK;
      default: rd_data = 8'h00;
    endcase
  end

  // ack of a received byte happens on the ninth clock, data latched at the falling clock that starts the ack
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
      bit_cnt <= 3'd0;
      shift <= 8'h00;
      index <= 8'h00;
      is_read <= 1'b0;
      have_index <= 1'b0;
      ack_drive <= 1'b0;
      sda_low <= 1'b0;
      pwr <= `ACRL_PWR_RESET;
      dig <= `ACRL_DIG_RESET;
      pending <= 1'b0;
    end else begin
      if (I_SAMPLE_STB)
        pending <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        bit_cnt <= 3'd0;
        have_index <= 1'b0;
        ack_drive <= 1'b0;
        sda_low <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
        sda_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: sda_low <= 1'b0;
          ST_ADDR, ST_WRX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7)
                ack_drive <= 1'b1;
            end
            // a full byte is decoded only at its own falling clock, never on stale bits
            if (scl_fall && ack_drive) begin
              ack_drive <= 1'b0;
              bit_cnt <= 3'd0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == DEV_ADDR) begin
                  is_read <= shift[0];
                  sda_low <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  state <= ST_SKIP;
                end
              end else begin
                sda_low <= 1'b1;
                state <= ST_ACK;
                if (!have_index) begin
                  index <= shift;
                  have_index <= 1'b1;
                end else begin
                  if (index == `ACRL_OFS_PWR) begin
                    pwr <= shift;
                    pending <= 1'b1;
                  end else if (index == `ACRL_OFS_DIG) begin
                    dig <= shift & `ACRL_DIG_WMASK;
                    pending <= 1'b1;
                  end
                  index <= index + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'd0;
              shift <= 8'h00;
              if (is_read) begin
                state <= ST_RTX;
                shift <= {rd_data[6:0], 1'b0};
                sda_low <= ~rd_data[7];
              end else begin
                state <= ST_WRX;
                sda_low <= 1'b0;
              end
            end
          end
          ST_RTX: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7) begin
                sda_low <= 1'b0;
                state <= ST_RACK;
              end else begin
                sda_low <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda) begin
                state <= ST_SKIP;
              end else begin
                index <= index + 8'h01;
                is_read <= 1'b1;
                state <= ST_ACK;
              end
            end
          end
          ST_SKIP: sda_low <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign O_SDA = 1'b0;
  assign O_SDA_OE = sda_low;

  // controls move to the audio path only on a sample boundary
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CLIP_THRESHOLD_HI <= 6'h3f;
      O_AMP_SLEEP <= 1'b0;
      O_AMP_SHUTDOWN_N <= 1'b1;
      O_POWER_STAGE_EN <= 1'b1;
      O_HIGHPASS_SKIP <= 1'b0;
      O_BOOST <= 2'h1;
      O_BOOST_DB <= 5'h06;
      O_RATE_SPEED_SELECT <= 1'b0;
      O_FORMAT <= 3'h4;
      O_FORMAT_BITS <= 5'h18;
      O_FORMAT_I2S <= 1'b1;
      O_FORMAT_LEFT <= 1'b0;
    end else if (I_SAMPLE_STB && pending) begin
      O_CLIP_THRESHOLD_HI <= pwr[`ACRL_PWR_CLIP_HI:`ACRL_PWR_CLIP_LO];
      O_AMP_SLEEP <= pwr[`ACRL_PWR_SLEEP];
      O_AMP_SHUTDOWN_N <= pwr[`ACRL_PWR_SD_N];
      O_POWER_STAGE_EN <= pwr[`ACRL_PWR_SD_N] & ~pwr[`ACRL_PWR_SLEEP];
      O_HIGHPASS_SKIP <= dig[`ACRL_DIG_HPF];
      O_BOOST <= dig[`ACRL_DIG_BOOST_HI:`ACRL_DIG_BOOST_LO];
      case (dig[`ACRL_DIG_BOOST_HI:`ACRL_DIG_BOOST_LO])
        2'h0: O_BOOST_DB <= 5'h00;
        2'h1: O_BOOST_DB <= 5'h06;
        2'h2: O_BOOST_DB <= 5'h0c;
        default: O_BOOST_DB <= 5'h12;
      endcase
      O_RATE_SPEED_SELECT <= dig[`ACRL_DIG_SPEED];
      O_FORMAT <= dig[`ACRL_DIG_FMT_HI:`ACRL_DIG_FMT_LO];
      O_FORMAT_I2S <= dig[2:0] == 3'h4;
      O_FORMAT_LEFT <= dig[2:0] == 3'h5;
      // reserved codes are the host's fault; they fall back to 24 bits
      case (dig[`ACRL_DIG_FMT_HI:`ACRL_DIG_FMT_LO])
        3'h1: O_FORMAT_BITS <= 5'h14;
        3'h2: O_FORMAT_BITS <= 5'h12;
        3'h3: O_FORMAT_BITS <= 5'h10;
        default: O_FORMAT_BITS <= 5'h18;
      endcase
    end
  end
endmodule

/* sim/acrl_top_checker.sv */
// assertions on the applied controls and data pin of acrl_top
// assumes it is bound to acrl_top and sees only its ports
`timescale 1ns/1ps
module acrl_chk (
  // clock and reset
  input wire I_CLK,
  input wire I_NRST,
  // control port and timing
  input wire I_SCL,
  input wire I_SAMPLE_STB,
  input wire O_SDA,
  input wire O_SDA_OE,
  // applied controls
  input wire [5:0] O_CLIP_THRESHOLD_HI,
  input wire O_AMP_SLEEP,
  input wire O_AMP_SHUTDOWN_N,
  input wire O_POWER_STAGE_EN,
  input wire [1:0] O_BOOST,
  input wire [4:0] O_BOOST_DB,
  input wire [2:0] O_FORMAT,
  input wire [4:0] O_FORMAT_BITS,
  input wire O_FORMAT_I2S,
  input wire O_FORMAT_LEFT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  sequence s_idle;
    !I_SAMPLE_STB;
  endsequence
  // a write alone must not disturb the audio path mid-sample
  property p_hold; s_idle |=> $stable({O_CLIP_THRESHOLD_HI, O_AMP_SLEEP,
    O_AMP_SHUTDOWN_N, O_BOOST, O_FORMAT}); endproperty
  property p_db; O_BOOST_DB == 5'(O_BOOST) * 5'h6; endproperty
  property p_bits; O_FORMAT_BITS == (O_FORMAT == 3'h1 ? 5'h14 : O_FORMAT == 3'h2 ?
    5'h12 : O_FORMAT == 3'h3 ? 5'h10 : 5'h18); endproperty
  property p_i2s; O_FORMAT_I2S == (O_FORMAT == 3'h4); endproperty
  property p_left; O_FORMAT_LEFT == (O_FORMAT == 3'h5); endproperty
  property p_stage; O_POWER_STAGE_EN == (O_AMP_SHUTDOWN_N & !O_AMP_SLEEP); endproperty
  // letting go of data with the clock high would look like a stop on the bus
  property p_sda; $fell(O_SDA_OE) |-> !I_SCL && O_SDA == 1'b0; endproperty
  property p_ack; $rose(O_SDA_OE) |-> !I_SCL; endproperty
  a_hold: assert property (p_hold) else $error("control moved off strobe");
  a_db: assert property (p_db) else $error("boost gain wrong");
  a_bits: assert property (p_bits) else $error("format width wrong");
  a_i2s: assert property (p_i2s) else $error("i2s flag wrong");
  a_left: assert property (p_left) else $error("left flag wrong");
  a_stage: assert property (p_stage) else $error("stage enable wrong");
  a_sda: assert property (p_sda) else $error("data released with clock high");
  a_ack: assert property (p_ack) else $error("data pulled with clock high");
endmodule
bind acrl_top acrl_chk u_chk (.*);

/* sim/acrl_host.sv */
// behavioural two-wire host for the control port
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module acrl_host (
  // bench clock and resolved data
  input wire clk,
  input wire sda,
  // driven lines
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves only with scl low, so no false start or stop
  task automatic bt(input logic b, output logic r);
    sda_oe <= ~b;
    w(10);
    scl <= 1'b1;
    w(5);
    r = sda;
    w(5);
    scl <= 1'b0;
    w(4);
  endtask
  task automatic start;
    sda_oe <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(10);
    sda_oe <= 1'b1;
    w(10);
    scl <= 1'b0;
    w(4);
  endtask
  task automatic stop;
    sda_oe <= 1'b1;
    w(10);
    scl <= 1'b1;
    w(10);
    sda_oe <= 1'b0;
    w(10);
  endtask
  // last is the ninth bit: 1 releases for an ack, or nacks a read
  task automatic xf(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(last, r);
    a = ~r;
  endtask
endmodule

/* sim/tb_amp_control_registers_low.sv */
// self-checking bench for acrl_top driven through a two-wire host
// assumes acrl_host and the bound checker are compiled first
`timescale 1ns/1ps
`include "acrl_regs.vh"
module tb_amp_control_registers_low;
  logic clk, nrst, stb;
  wire scl, hoe, oe, so, slp, sdn, pen, hps, rss, i2s, lft;
  wire [5:0] clip;
  wire [1:0] bst;
  wire [4:0] db, fb;
  wire [2:0] fmt;
  int errors, cmp_count;
  logic [31:0] seed = 32'h54b3;
  wire sda = (oe ? so : 1'b1) & ~hoe;
  acrl_host h (.clk(clk), .sda(sda), .scl(scl), .sda_oe(hoe));
  acrl_top dut (.I_CLK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda), .O_SDA(so),
    .O_SDA_OE(oe), .I_SAMPLE_STB(stb), .O_CLIP_THRESHOLD_HI(clip), .O_AMP_SLEEP(slp),
    .O_AMP_SHUTDOWN_N(sdn), .O_POWER_STAGE_EN(pen), .O_HIGHPASS_SKIP(hps),
    .O_BOOST(bst), .O_BOOST_DB(db), .O_RATE_SPEED_SELECT(rss), .O_FORMAT(fmt),
    .O_FORMAT_BITS(fb), .O_FORMAT_I2S(i2s), .O_FORMAT_LEFT(lft));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] fbits(input logic [2:0] f);
    return f == 3'h1 ? 5'h14 : f == 3'h2 ? 5'h12 : f == 3'h3 ? 5'h10 : 5'h18;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic outs(input logic [7:0] p, input logic [7:0] g);
    chk("clip", clip, p[7:2]);
    chk("power", {slp, sdn, pen}, {p[1], p[0], p[0] & ~p[1]});
    chk("hpf", hps, g[7]);
    chk("boost", {bst, db}, {g[5:4], 5'(g[5:4]) * 5'h6});
    chk("speed", rss, g[3]);
    chk("format", {fmt, fb, i2s, lft}, {g[2:0], fbits(g[2:0]), g[2:0] == 3'h4,
      g[2:0] == 3'h5});
  endtask
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    h.xf(d, 1'b1, q, a);
    chk("ack", a, 1'b1);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b0});
    wb(i);
    wb(d);
    h.stop();
  endtask
  task automatic rchk(input string n, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] d;
    logic a;
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b0});
    wb(i);
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b1});
    h.xf(8'hff, 1'b1, d, a);
    h.stop();
    chk(n, d, e);
  endtask
  // both controls in one write, then read back with a master ack in between
  task automatic burst(input logic [7:0] p, input logic [7:0] g);
    logic [7:0] d0;
    logic [7:0] d1;
    logic a;
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b0});
    wb(`ACRL_OFS_PWR);
    wb(p);
    wb(g);
    h.stop();
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b0});
    wb(`ACRL_OFS_PWR);
    h.start();
    wb({`ACRL_DEV_ADDR, 1'b1});
    h.xf(8'hff, 1'b0, d0, a);
    h.xf(8'hff, 1'b1, d1, a);
    h.stop();
    chk("burst pwr", d0, p);
    chk("burst dig", d1, g & `ACRL_DIG_WMASK);
  endtask
  task automatic strobe;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] p, g, po, go;
    nrst = 1'b0;
    stb = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    po = `ACRL_PWR_RESET;
    go = `ACRL_DIG_RESET;
    outs(po, go);
    rchk("pwr", `ACRL_OFS_PWR, po);
    rchk("dig", `ACRL_OFS_DIG, go);
    wr(`ACRL_OFS_ID, 8'ha5);
    rchk("id", `ACRL_OFS_ID, `ACRL_ID_VALUE);
    $display("test reset and identity done");
    for (int i = 0; i < 6; i++) begin
      repeat (16) seed = lfsr(seed);
      p = seed[7:0];
      // format stays within the defined codes; bit six is set at random
      g = {seed[15:14], 2'(i), seed[11], 3'(i)};
      wr(`ACRL_OFS_PWR, p);
      wr(`ACRL_OFS_DIG, g);
      outs(po, go);
      strobe();
      g = g & `ACRL_DIG_WMASK;
      outs(p, g);
      rchk("pwr", `ACRL_OFS_PWR, p);
      rchk("dig", `ACRL_OFS_DIG, g);
      po = p;
      go = g;
    end
    $display("test random writes done");
    burst(8'h81, 8'hf5);
    outs(po, go);
    strobe();
    po = 8'h81;
    go = 8'hf5 & `ACRL_DIG_WMASK;
    outs(po, go);
    $display("test burst transfers done");
    wr(`ACRL_OFS_PWR, 8'h02);
    strobe();
    outs(8'h02, go);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    outs(`ACRL_PWR_RESET, `ACRL_DIG_RESET);
    rchk("pwr", `ACRL_OFS_PWR, `ACRL_PWR_RESET);
    $display("test sleep and second reset done");
    end_of_test();
  end
endmodule
